// File: rtl/piv_pkg.sv
// Purpose: shared constants and types for the priority interrupt vectoring block
// Assumes: 32-bit AHB-Lite register bus, one system clock
// Notes:   register offsets are byte addresses of aligned words
package piv_pkg;

    // source counts
    localparam int NUM_SRC  = 51;
    localparam int NUM_EXT  = 6;
    localparam int NUM_INT  = 44;
    localparam int NUM_PRIO = 13;
    localparam int SRC_W    = 6;

    // vector numbering
    localparam logic [6:0] VEC_NMI      = 7'h07;
    localparam logic [6:0] VEC_EXT0     = 7'h10;
    localparam int         VEC_ADDR_SH  = 2;
    localparam logic [2:0] LVL_NMI      = 3'h7;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PRIO0    = 8'h04;
    localparam logic [7:0] OFS_PRIO_END = 8'h34;
    localparam logic [7:0] OFS_STATUS   = 8'h38;

    // control register fields
    localparam int         CTRL_MODE_LO = 0;
    localparam int         CTRL_MODE_HI = 1;
    localparam logic [1:0] MODE_0       = 2'h0;
    localparam logic [1:0] MODE_2       = 2'h2;

    // priority register layout
    localparam logic [7:0] PRIO_WMASK   = 8'h77;
    localparam logic [7:0] PRIO_RST     = 8'h77;
    localparam int         PRIO_UP_LSB  = 4;

    // status register fields
    localparam int STAT_VLD_BIT = 7;
    localparam int STAT_LVL_LSB = 8;

    // bus encodings
    localparam logic       HRESP_OKAY   = 1'b0;

    // presentation states, gray along idle -> present -> done
    typedef enum logic [1:0] {
        PIV_IDLE    = 2'b00,
        PIV_PRESENT = 2'b01,
        PIV_DONE    = 2'b11
    } piv_state_t;

    // what the cpu sees
    typedef struct packed {
        logic        valid;
        logic [6:0]  vector;
        logic [2:0]  level;
        logic [15:0] vec_addr;
    } piv_cpu_req_t;

    typedef logic [NUM_PRIO-1:0][7:0] piv_prio_t;

endpackage

// File: rtl/piv_arbiter.sv
// Purpose: pick the highest level eligible source, lowest index on ties
// Assumes: sources are ordered by ascending vector number
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module piv_arbiter #(
    parameter int N = 51,
    parameter int W = 6
) (
    // candidates
    input  wire logic [N-1:0]   elig,
    input  wire logic [N*3-1:0] lvl,
    // winner
    output logic                found,
    output logic [W-1:0]        idx,
    output logic [2:0]          best
);

    // strict compare keeps the earliest (lowest vector) of equal levels
    always_comb
    begin
        found = 1'b0;
        idx   = '0;
        best  = '0;
        for (int i = 0; i < N; i++)
        begin
            if (elig[i] && (!found || lvl[i*3 +: 3] > best))
            begin
                found = 1'b1;
                idx   = W'(i);
                best  = lvl[i*3 +: 3];
            end
        end
    end

endmodule
`default_nettype wire

// File: rtl/piv_top.sv
// Purpose: interrupt controller with vector, level and acceptance to the cpu
// Assumes: request inputs are synchronous active-high levels held until served
// Notes:
// Notes on behaviour
// - fifty-one sources: nmi, six pins, forty-four modules
// - each source owns a distinct vector
// - mode field 00 or 10; others prohibited
// - acceptance uses mode, priorities, masks
// - mode 0 passes requests only when mask clear
// - mode 2 compares level against mask level
// - nmi highest, never masked, vector 7
// - vector address is four times vector
// - pins use vectors 16-21, fields A/B
// - modules use 24-127; 22, 23 unused
// - transfer-done uses vector 24, field C lower
// - watchdog 25, break 27, conversion 28
// - timer0 vectors 32-36, field F upper
// - timer1 vectors 40-43, field F lower
// - timer2 vectors 44-47, field G upper
// - timer3 vectors 48-52, field G lower
// - timer4 vectors 56-59, field H upper
// - timer5 vectors 60-63, field H lower
// - no detection while cpu disallows it
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module piv_top #(
    parameter int NUM_INT = piv_pkg::NUM_INT
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // request lines
    input  wire logic                 nmi_req,
    input  wire logic [5:0]           ext_req_pin,
    input  wire logic [NUM_INT-1:0]   module_req,
    // cpu side
    input  wire logic                 cpu_global_mask,
    input  wire logic [2:0]           mask_level_field,
    input  wire logic                 cpu_detect_en,
    input  wire logic                 cpu_ack,
    output piv_pkg::piv_cpu_req_t     cpu_req
);

    localparam int N = piv_pkg::NUM_SRC;

    // vector of each source, index order is ascending vector
    // distinct vectors
    function automatic logic [6:0] src_vec(input int i);
        if (i == 0)       return piv_pkg::VEC_NMI;
        else if (i <= 6)  return 7'(15 + i);     // pins 16..21
        else if (i == 7)  return 7'h18;          // transfer done 24
        else if (i == 8)  return 7'h19;          // watchdog 25
        else if (i <= 10) return 7'(18 + i);     // break 27, conversion 28
        else if (i <= 15) return 7'(21 + i);     // timer0 32..36
        else if (i <= 28) return 7'(24 + i);     // timers 1-3, 40..52
        else if (i <= 36) return 7'(27 + i);     // timers 4-5, 56..63
        else if (i <= 48) return 7'(43 + i);     // serial 80..91
        else              return 7'(55 + i);     // 104, 105
    endfunction

    // priority field: bit0 set for lower field, upper bits select register
    // source fields
    function automatic logic [4:0] src_field(input int i);
        if (i <= 2)       return 5'(i - 1);      // A upper, A lower
        else if (i <= 4)  return 5'h02;          // B upper
        else if (i <= 6)  return 5'h03;          // B lower
        else if (i == 7)  return 5'h05;          // C lower
        else if (i == 8)  return 5'h06;          // D upper
        else if (i == 9)  return 5'h08;          // E upper
        else if (i == 10) return 5'h09;          // E lower
        else if (i <= 15) return 5'h0A;          // F upper
        else if (i <= 19) return 5'h0B;          // F lower
        else if (i <= 23) return 5'h0C;
        else if (i <= 28) return 5'h0D;
        else if (i <= 32) return 5'h0E;
        else if (i <= 36) return 5'h0F;
        else if (i <= 40) return 5'h13;          // J lower
        else if (i <= 44) return 5'h14;          // K upper
        else if (i <= 48) return 5'h15;          // K lower
        else              return 5'h18;          // M upper
    endfunction

    // register state
    logic [1:0]          mode;
    logic [1:0]          next_mode;
    piv_pkg::piv_prio_t  prio;
    piv_pkg::piv_prio_t  next_prio;
    logic                wr_pend;
    logic                next_wr_pend;
    logic [7:0]          wr_addr;
    logic [7:0]          next_wr_addr;
    logic [31:0]         next_hrdata;

    // presentation state
    piv_pkg::piv_state_t  state;
    piv_pkg::piv_state_t  next_state;
    piv_pkg::piv_cpu_req_t next_cpu_req;

    // request collection
    // fifty-one sources
    var  logic [N-1:0]   req_all;
    wire logic [N-1:0]   elig;    // per-source slices driven separately
    wire logic [N*3-1:0] lvl;     // per-source slices driven separately
    var  logic           found;
    var  logic [5:0]     win_idx;
    var  logic [2:0]     win_lvl;

    assign req_all = {module_req, ext_req_pin, nmi_req};

    // per-source level and mask gating
    generate
        for (genvar g = 1; g < N; g++)
        begin : g_src
            logic [4:0] fld;
            logic [7:0] pbyte;
            logic [2:0] plvl;
            assign fld   = src_field(g);
            assign pbyte = prio[fld[4:1]];
            assign plvl  = fld[0] ? pbyte[2:0] : pbyte[piv_pkg::PRIO_UP_LSB +: 3];
            assign lvl[g*3 +: 3] = (mode == piv_pkg::MODE_2) ? plvl : 3'h0;
            assign elig[g] = req_all[g] &&
                ((mode == piv_pkg::MODE_2) ? (plvl > mask_level_field)
                                           : !cpu_global_mask);
        end
    endgenerate

    assign elig[0]  = req_all[0];
    assign lvl[2:0] = piv_pkg::LVL_NMI;

    piv_arbiter #(
        .N (N),
        .W (piv_pkg::SRC_W)
    ) u_arb (
        .elig  (elig),
        .lvl   (lvl),
        .found (found),
        .idx   (win_idx),
        .best  (win_lvl)
    );

    // vector table lookup of the winner
    logic [6:0] win_vec;
    always_comb
    begin
        win_vec = '0;
        for (int i = 0; i < N; i++)
        begin
            if (win_idx == 6'(i))
                win_vec = src_vec(i);
        end
    end

    // presentation next state
    always_comb
    begin
        next_state   = state;
        next_cpu_req = cpu_req;
        case (state)
            piv_pkg::PIV_IDLE:
            begin
                if (cpu_detect_en && found)
                begin
                    next_state            = piv_pkg::PIV_PRESENT;
                    next_cpu_req.valid    = 1'b1;
                    next_cpu_req.vector   = win_vec;
                    next_cpu_req.level    = elig[0] ? piv_pkg::LVL_NMI : win_lvl;
                    next_cpu_req.vec_addr = 16'(win_vec) << piv_pkg::VEC_ADDR_SH;
                end
            end
            piv_pkg::PIV_PRESENT:
            begin
                if (cpu_ack)
                begin
                    next_state         = piv_pkg::PIV_DONE;
                    next_cpu_req.valid = 1'b0;
                end
            end
            // one quiet cycle lets the source drop its line
            default:
                next_state = piv_pkg::PIV_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state   <= piv_pkg::PIV_IDLE;
            cpu_req <= '0;
        end
        else
        begin
            state   <= next_state;
            cpu_req <= next_cpu_req;
        end
    end

    // bus next values: address phase latches, data phase writes
    always_comb
    begin
        next_mode    = mode;
        next_prio    = prio;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_hrdata  = '0;
        if (wr_pend)
        begin
            if (wr_addr == piv_pkg::OFS_CTRL)
            begin
                if (!hwdata[piv_pkg::CTRL_MODE_LO])
                    next_mode = hwdata[piv_pkg::CTRL_MODE_HI:piv_pkg::CTRL_MODE_LO];
            end
            else if (wr_addr >= piv_pkg::OFS_PRIO0 && wr_addr <= piv_pkg::OFS_PRIO_END)
            begin
                next_prio[4'((wr_addr - piv_pkg::OFS_PRIO0) >> 2)] =
                    hwdata[7:0] & piv_pkg::PRIO_WMASK;
            end
        end
        if (hsel && hready && htrans[1])
        begin
            next_wr_pend = hwrite;
            next_wr_addr = haddr[7:0];
            if (!hwrite)
            begin
                if (haddr[7:0] == piv_pkg::OFS_CTRL)
                    next_hrdata = 32'(mode);
                else if (haddr[7:0] >= piv_pkg::OFS_PRIO0 &&
                         haddr[7:0] <= piv_pkg::OFS_PRIO_END && haddr[1:0] == 2'h0)
                    next_hrdata = 32'(prio[4'((haddr[7:0] - piv_pkg::OFS_PRIO0) >> 2)]);
                else if (haddr[7:0] == piv_pkg::OFS_STATUS)
                    next_hrdata = 32'({cpu_req.level, cpu_req.valid, cpu_req.vector});
                else
                    next_hrdata = '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode      <= piv_pkg::MODE_0;
            prio      <= {piv_pkg::NUM_PRIO{piv_pkg::PRIO_RST}};
            wr_pend   <= 1'b0;
            wr_addr   <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= piv_pkg::HRESP_OKAY;
        end
        else
        begin
            mode      <= next_mode;
            prio      <= next_prio;
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= piv_pkg::HRESP_OKAY;
        end
    end

    // checks on the mode register and the presented request
    mode_legal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !mode[piv_pkg::CTRL_MODE_LO]) else $error("prohibited mode held");
    nmi_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == piv_pkg::PIV_IDLE && cpu_detect_en && nmi_req)
        |=> (cpu_req.valid && cpu_req.vector == piv_pkg::VEC_NMI))
        else $error("nmi not presented");
    hold_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cpu_req.valid && !cpu_ack) |=> (cpu_req.valid && $stable(cpu_req)))
        else $error("request changed before ack");
    ack_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cpu_req.valid && cpu_ack) |=> !cpu_req.valid ##1 (state == piv_pkg::PIV_IDLE))
        else $error("ack not honoured");
    mask0_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == piv_pkg::PIV_IDLE && mode == piv_pkg::MODE_0 && cpu_global_mask
         && !nmi_req) |=> !cpu_req.valid) else $error("masked request passed");
    mode2_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(cpu_req.valid) && cpu_req.vector != piv_pkg::VEC_NMI
         && $past(mode) == piv_pkg::MODE_2)
        |-> cpu_req.level > $past(mask_level_field)) else $error("level not above mask");
    detect_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == piv_pkg::PIV_IDLE && !cpu_detect_en) |=> !cpu_req.valid)
        else $error("detected while disallowed");
    vec_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cpu_req.valid |-> cpu_req.vec_addr == {7'h00, cpu_req.vector, 2'h0})
        else $error("vector address mismatch");
    reserved_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cpu_req.valid |-> !(cpu_req.vector inside {7'h16, 7'h17, [7'h35:7'h37]}))
        else $error("reserved vector issued");

endmodule
`default_nettype wire

// File: bench/piv_cpu_model.sv
// Purpose: cpu side model that accepts presented requests
// Assumes: request arrives as piv_cpu_req_t from flops
// Notes:   ack_delay sets how long the cpu stalls
`timescale 1ns/1ps
`default_nettype none
module piv_cpu_model (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // controller side
    input  wire piv_pkg::piv_cpu_req_t cpu_req,
    input  wire logic [7:0]            ack_delay,
    output logic                       cpu_ack
);
    logic [7:0] wait_cnt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_cnt <= 8'h00;
            cpu_ack  <= 1'b0;
        end
        else if (cpu_req.valid && !cpu_ack)
        begin
            cpu_ack  <= (wait_cnt >= ack_delay);
            wait_cnt <= (wait_cnt >= ack_delay) ? 8'h00 : wait_cnt + 8'h01;
        end
        else
            cpu_ack <= 1'b0; // one-cycle pulse
    end
endmodule
`default_nettype wire

// File: bench/test_piv_top.sv
// Purpose: self-checking bench for the interrupt vectoring block
// Assumes: zero-wait ahb slave, cpu model acks after ack_delay
// Notes:   source index order follows ascending vector number
`timescale 1ns/1ps
`default_nettype none
module test_piv_top;
    logic                  hclk = 1'b0;
    logic                  hresetn = 1'b0;
    logic                  hsel = 1'b0;
    logic [31:0]           haddr = 32'h0;
    logic [1:0]            htrans = 2'h0;
    logic                  hwrite = 1'b0;
    logic [2:0]            hsize = 3'h0;
    logic [31:0]           hwdata = 32'h0;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
    logic                  nmi_req = 1'b0;
    logic [5:0]            ext_req_pin = 6'h00;
    logic [43:0]           module_req = 44'h0;
    logic                  gmask = 1'b0;
    logic [2:0]            mlevel = 3'h0;
    logic                  detect_en = 1'b1;
    logic                  cpu_ack;
    logic [7:0]            ack_delay = 8'h02;
    piv_pkg::piv_cpu_req_t cpu_req;
    logic [31:0]           rd;
    int                    fail_count = 0;
    int                    n_checks = 0;

    // clock
    always #10 hclk = ~hclk;

    // design and cpu model
    piv_top i_piv_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .nmi_req(nmi_req), .ext_req_pin(ext_req_pin), .module_req(module_req),
        .cpu_global_mask(gmask), .mask_level_field(mlevel), .cpu_detect_en(detect_en),
        .cpu_ack(cpu_ack), .cpu_req(cpu_req));
    piv_cpu_model i_piv_cpu_model (.hclk(hclk), .hresetn(hresetn), .cpu_req(cpu_req),
        .ack_delay(ack_delay), .cpu_ack(cpu_ack));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one ahb single transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    function automatic logic [6:0] src_vec(input int i);
        if (i == 0) return 7'h07;
        if (i <= 6) return 7'(i + 15);
        if (i <= 8) return 7'(i + 17);
        if (i <= 10) return 7'(i + 18);
        if (i <= 15) return 7'(i + 21);
        if (i <= 28) return 7'(i + 24);
        if (i <= 36) return 7'(i + 27);
        if (i <= 48) return 7'(i + 43);
        return 7'(i + 55);
    endfunction

    task automatic set_src(input int i, input logic v);
        @(posedge hclk);
        if (i == 0) nmi_req <= v;
        else if (i <= 6) ext_req_pin[i-1] <= v;
        else module_req[i-7] <= v;
    endtask

    task automatic wait_valid;
        int k;
        k = 0;
        do
        begin
            @(negedge hclk);
            k++;
        end
        while (cpu_req.valid !== 1'b1 && k < 40);
        chk(cpu_req.valid, 1'b1);
    endtask

    task automatic wait_idle;
        int k;
        k = 0;
        while (cpu_req.valid !== 1'b0 && k < 40)
        begin
            @(negedge hclk);
            k++;
        end
        chk(cpu_req.valid, 1'b0);
        repeat (2) @(posedge hclk);
    endtask

    task automatic expect_none(input int n);
        repeat (n)
        begin
            @(negedge hclk);
            chk(cpu_req.valid, 1'b0);
        end
    endtask

    // take one source, check what is presented
    task automatic serve(input int i, input logic [2:0] lvl);
        wait_valid();
        set_src(i, 1'b0);
        chk(cpu_req.vector, src_vec(i));
        chk(cpu_req.vec_addr, {7'h0, src_vec(i), 2'h0});
        chk(cpu_req.level, lvl);
        wait_idle();
    endtask

    // register reset values, masks and prohibited modes
    task automatic t_regs;
        rdchk(piv_pkg::OFS_CTRL, 32'h0);
        for (int k = 0; k < 13; k++)
            rdchk(8'(piv_pkg::OFS_PRIO0 + 4 * k), 32'h77);
        rdchk(piv_pkg::OFS_STATUS, 32'h0);
        rdchk(8'h3C, 32'h0);
        bus(1'b1, piv_pkg::OFS_PRIO0, 32'hFF);
        rdchk(piv_pkg::OFS_PRIO0, 32'h77);
        bus(1'b1, piv_pkg::OFS_STATUS, 32'hFFFF);
        rdchk(piv_pkg::OFS_STATUS, 32'h0);
        bus(1'b1, piv_pkg::OFS_CTRL, 32'h1);
        rdchk(piv_pkg::OFS_CTRL, 32'h0);
        bus(1'b1, piv_pkg::OFS_CTRL, 32'h2);
        bus(1'b1, piv_pkg::OFS_CTRL, 32'h3);
        rdchk(piv_pkg::OFS_CTRL, 32'h2);
        bus(1'b1, piv_pkg::OFS_CTRL, 32'h0);
        rdchk(piv_pkg::OFS_CTRL, 32'h0);
    endtask

    // every source alone in mode 0
    task automatic t_vectors;
        for (int i = 0; i < 51; i++)
        begin
            set_src(i, 1'b1);
            serve(i, (i == 0) ? 3'h7 : 3'h0);
        end
    endtask

    // global mask blocks all but the non-maskable pin
    task automatic t_mode0;
        @(posedge hclk) gmask <= 1'b1;
        set_src(1, 1'b1);
        expect_none(8);
        set_src(0, 1'b1);
        serve(0, 3'h7);
        expect_none(4);
        @(posedge hclk) gmask <= 1'b0;
        serve(1, 3'h0);
    endtask

    // level compare, boundary and ties in mode 2
    task automatic t_mode2;
        bus(1'b1, piv_pkg::OFS_CTRL, 32'h2);
        bus(1'b1, piv_pkg::OFS_PRIO0, 32'h35);
        bus(1'b1, 8'(piv_pkg::OFS_PRIO0 + 4), 32'h50);
        @(posedge hclk) mlevel <= 3'h4;
        set_src(1, 1'b1);
        expect_none(6);
        set_src(2, 1'b1);
        serve(2, 3'h5);
        @(posedge hclk) mlevel <= 3'h2;
        serve(1, 3'h3);
        @(posedge hclk) mlevel <= 3'h5;
        @(posedge hclk) ext_req_pin <= 6'h0C;
        expect_none(6);
        @(posedge hclk) mlevel <= 3'h4;
        serve(3, 3'h5);
        serve(4, 3'h5);
        bus(1'b1, piv_pkg::OFS_CTRL, 32'h0);
    endtask

    // detection gate, then hold while the cpu stalls
    task automatic t_detect;
        @(posedge hclk) detect_en <= 1'b0;
        set_src(1, 1'b1);
        expect_none(6);
        @(posedge hclk) detect_en <= 1'b1;
        ack_delay <= 8'h0C;
        wait_valid();
        set_src(1, 1'b0);
        repeat (3) @(negedge hclk);
        chk(cpu_req.valid, 1'b1);
        chk(cpu_req.vector, 7'h10);
        rdchk(piv_pkg::OFS_STATUS, 32'h90);
        wait_idle();
        ack_delay <= 8'h02;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog against hangs
    initial
    begin
        #400000;
        fail_count++;
        complete_run();
    end

    // main sequence
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_vectors();
        t_mode0();
        t_mode2();
        t_detect();
        complete_run();
    end
endmodule
`default_nettype wire
